// ---- core/ddmar_regs.sv ----
// Register bank and address/count generator for one distributed DMA
// channel. Assumes byte-wide I/O cycles already qualified by the PCI
// target, and a sequencer that pulses xfer_done once per data transfer.
//
// Notes on behaviour
// - Registers decode in a 16-byte I/O window whose base comes from config offset 98h.
// - Legacy bits with no PCI meaning are read-only and do nothing.
// - Reserved locations read zero and ignore writes.
// - Writing offset 00h loads the base address; reading gives the current address.
// - In 8-bit mode the address goes on AD15-0 and page 7-0 on AD23-16.
// - In 16-bit mode the address goes on AD16-1, AD0 is low, page 7-1 on AD23-17.
// - Offset 02h is an 8-bit read/write page register resetting to zero.
// - Writing offset 04h sets the byte count; reading gives the remaining count.
// - Each transfer decrements the count by 1 in 8-bit mode and 2 in 16-bit mode.
// - Command bit 2 low keeps the controller enabled, high disables it.
// - Command bits 7-3 and 1-0 read as zero and are not writable.
// - Address and count registers reset to zero.
// - Mode bit 5 low increments the address per transfer, high decrements it.
// - Terminal count sets status bits 3-0, cleared by reading or channel reset.
`timescale 1ns/1ps
module ddmar_regs
    import ddmar_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Window base from configuration space
    input  wire logic [15:0] io_base,
    // I/O byte access
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_hit,
    // Transfer sequencer
    input  wire logic        width16,
    input  wire logic        xfer_done,
    input  wire logic        chan_reset,
    output logic      [23:0] pci_addr,
    output logic             ctrl_enabled,
    output logic             terminal_count
);

    // Each register group below has one next-state process and one
    // flop process. Host writes come a byte at a time, so a 16-bit
    // register is loaded low byte and high byte separately; a user who
    // writes only one half while transfers run gets a mixed value.
    // Nothing here checks the card side: a step is trusted as given.
    // Reads answer one cycle after the strobe, from the flops at the
    // end of the file, so the host must allow that one cycle.

    // Register state and next values
    logic [15:0] xfer_address_r;
    logic [15:0] xfer_address_nxt;
    logic [7:0]  address_page_r;
    logic [7:0]  address_page_nxt;
    logic [15:0] xfer_count_r;
    logic [15:0] xfer_count_nxt;
    logic [7:0]  command_r;
    logic [7:0]  command_nxt;
    logic [7:0]  mode_r;
    logic [7:0]  mode_nxt;
    logic [3:0]  tc_flags_r;
    logic [3:0]  tc_flags_nxt;
    // Output images ahead of their flops
    logic [7:0]  io_rdata_nxt;
    logic        io_hit_nxt;
    logic [23:0] pci_addr_nxt;
    logic        ctrl_enabled_nxt;
    logic        terminal_count_nxt;
    // Access decode and step control
    logic        hit;
    logic [3:0]  ofs;
    logic        wr;
    logic        rd;
    logic        step;
    logic        reach_tc;
    logic        status_rd;
    logic [15:0] cnt_step;

    // Window match; base aligned to 16 bytes
    function automatic logic in_window(input logic [15:0] a,
                                       input logic [15:0] b);
        return (a[15:4] == b[15:4]);
    endfunction : in_window

    // Slot match inside the window; shared by every register group
    function automatic logic at_slot(input logic [3:0] o,
                                     input logic [3:0] slot);
        return (o == slot);
    endfunction : at_slot

    // Access qualification. The window base comes from configuration
    // space and is held outside; its low four bits are ignored, so any
    // base is treated as aligned.
    assign hit       = in_window(io_addr, io_base);
    assign ofs       = io_addr[3:0] & WIN_MASK;
    assign wr        = io_wr & hit;
    assign rd        = io_rd & hit;
    assign status_rd = rd & at_slot(ofs, OFS_CMD_STAT);
    // Reserved slots match no group below, so writes there are lost

    // Disabled controller freezes address and count
    assign step      = xfer_done & ~command_r[CMD_OFF_BIT];
    // 16-bit mode steps the count by two bytes per word
    assign cnt_step  = width16 ? STEP_16 : STEP_8;
    // TC when the count would run out on this step; an underflow
    // past zero is flagged too rather than wrapping silently
    assign reach_tc  = step && (xfer_count_r <= cnt_step);

    // Current address: steps move it by one whatever the width, and
    // a host byte written in the same cycle beats the step.
    // Wraps at either end of the 16-bit space; the page byte never
    // carries, so software must keep a transfer inside one page.
    always_comb begin
        xfer_address_nxt = xfer_address_r;
        if (step) begin
            if (mode_r[MODE_DIR_BIT]) begin
                xfer_address_nxt = xfer_address_r - STEP_8;
            end else begin
                xfer_address_nxt = xfer_address_r + STEP_8;
            end
        end
        if (wr && at_slot(ofs, OFS_ADDR_LO)) begin
            xfer_address_nxt[7:0] = io_wdata;
        end
        if (wr && at_slot(ofs, OFS_ADDR_HI)) begin
            xfer_address_nxt[15:8] = io_wdata;
        end
    end

    // Address register; a channel reset leaves the pointer alone
    always_ff @(posedge clk) begin
        if (reset) begin
            xfer_address_r <= ADDR_RST;
        end else begin
            xfer_address_r <= xfer_address_nxt;
        end
    end

    // Page byte: host-written only, never stepped.
    // Bit 0 still reads back in 16-bit mode; only the image drops it.
    always_comb begin
        address_page_nxt = address_page_r;
        if (wr && at_slot(ofs, OFS_PAGE)) begin
            address_page_nxt = io_wdata;
        end
    end

    // Page register
    always_ff @(posedge clk) begin
        if (reset) begin
            address_page_r <= PAGE_RST;
        end else begin
            address_page_r <= address_page_nxt;
        end
    end

    // Remaining count: steps take one byte or two, and a host byte
    // written in the same cycle beats the step. In 16-bit mode an odd
    // count steps past zero and raises the flags on its last word.
    always_comb begin
        xfer_count_nxt = xfer_count_r;
        if (step) begin
            xfer_count_nxt = xfer_count_r - cnt_step;
        end
        if (wr && at_slot(ofs, OFS_COUNT_LO)) begin
            xfer_count_nxt[7:0] = io_wdata;
        end
        if (wr && at_slot(ofs, OFS_COUNT_HI)) begin
            xfer_count_nxt[15:8] = io_wdata;
        end
    end

    // Count register; a channel reset clears only the flags
    always_ff @(posedge clk) begin
        if (reset) begin
            xfer_count_r <= COUNT_RST;
        end else begin
            xfer_count_r <= xfer_count_nxt;
        end
    end

    // Command byte: only the off bit is kept, the rest stays zero.
    // A write to the off bit takes effect from the next edge.
    always_comb begin
        command_nxt = command_r;
        if (wr && at_slot(ofs, OFS_CMD_STAT)) begin
            command_nxt = io_wdata & CMD_RW_MASK;
        end
    end

    // Command register; reset leaves the controller enabled
    always_ff @(posedge clk) begin
        if (reset) begin
            command_r <= CMD_RST;
        end else begin
            command_r <= command_nxt;
        end
    end

    // Mode byte: write-only here; the low two bits are dead legacy
    // bits and only the direction bit has any effect. The other stored
    // bits feed nothing yet, so a later sequencer may use them freely.
    // The direction bit is looked at on every step.
    always_comb begin
        mode_nxt = mode_r;
        if (wr && at_slot(ofs, OFS_MODE)) begin
            mode_nxt = io_wdata & MODE_RW_MASK;
        end
    end

    // Mode register
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Terminal-count flags: a status read or channel reset clears them,
    // but a same-cycle terminal count wins so no end is ever lost.
    // All four move together: one channel sits behind this window, so
    // each legacy per-channel bit reports the same end.
    always_comb begin
        tc_flags_nxt = tc_flags_r;
        if (status_rd) begin
            tc_flags_nxt = 4'h0;
        end
        if (chan_reset) begin
            tc_flags_nxt = 4'h0;
        end
        if (reach_tc) begin
            tc_flags_nxt = TC_ALL;
        end
    end

    // Flag register
    always_ff @(posedge clk) begin
        if (reset) begin
            tc_flags_r <= 4'h0;
        end else begin
            tc_flags_r <= tc_flags_nxt;
        end
    end

    // Read data, registered one cycle after the strobe
    always_comb begin
        io_rdata_nxt = 8'h00;
        io_hit_nxt   = rd;
        if (rd) begin
            unique case (ofs)
                OFS_ADDR_LO:  io_rdata_nxt = xfer_address_r[7:0];
                OFS_ADDR_HI:  io_rdata_nxt = xfer_address_r[15:8];
                OFS_PAGE:     io_rdata_nxt = address_page_r;
                OFS_COUNT_LO: io_rdata_nxt = xfer_count_r[7:0];
                OFS_COUNT_HI: io_rdata_nxt = xfer_count_r[15:8];
                OFS_CMD_STAT: io_rdata_nxt = {4'h0, tc_flags_r};
                default:      io_rdata_nxt = 8'h00;
            endcase
        end
    end

    // Address-phase image of the current address
    always_comb begin
        if (width16) begin
            pci_addr_nxt = {address_page_r[7:1], xfer_address_r, 1'b0};
        end else begin
            pci_addr_nxt = {address_page_r, xfer_address_r};
        end
    end

    // Status and enable images, taken from the next state so the pins
    // agree with the registers on the same edge. Reset shows the
    // controller as off for as long as reset is held. Terminal count follows the
    // flags, so it drops the cycle after a status read and not before.
    always_comb begin
        ctrl_enabled_nxt   = ~command_nxt[CMD_OFF_BIT];
        terminal_count_nxt = |tc_flags_nxt;
    end

    // Output flops; every top-level output leaves from one of these.
    // Read data falls back to zero outside the answer cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            io_rdata       <= 8'h00;
            io_hit         <= 1'b0;
            pci_addr       <= 24'h000000;
            ctrl_enabled   <= 1'b0;
            terminal_count <= 1'b0;
        end else begin
            io_rdata       <= io_rdata_nxt;
            io_hit         <= io_hit_nxt;
            pci_addr       <= pci_addr_nxt;
            ctrl_enabled   <= ctrl_enabled_nxt;
            terminal_count <= terminal_count_nxt;
        end
    end

endmodule : ddmar_regs

// ---- core/ddmar_pkg.sv ----
// Constants for the distributed DMA slave register bank.
// Assumes a byte-wide register window decoded from an I/O base.
package ddmar_pkg;
    // Window geometry
    localparam int          WIN_BYTES      = 16;
    localparam logic [3:0]  WIN_MASK       = 4'hF;
    localparam logic [7:0]  CFG_BASE_OFS   = 8'h98;
    // Byte offsets inside the window
    localparam logic [3:0]  OFS_ADDR_LO    = 4'h0;
    localparam logic [3:0]  OFS_ADDR_HI    = 4'h1;
    localparam logic [3:0]  OFS_PAGE       = 4'h2;
    localparam logic [3:0]  OFS_COUNT_LO   = 4'h4;
    localparam logic [3:0]  OFS_COUNT_HI   = 4'h5;
    localparam logic [3:0]  OFS_CMD_STAT   = 4'h8;
    localparam logic [3:0]  OFS_MODE       = 4'hB;
    // Field positions
    localparam int          CMD_OFF_BIT    = 2;
    localparam int          MODE_DIR_BIT   = 5;
    localparam logic [7:0]  CMD_RW_MASK    = 8'h04;
    localparam logic [7:0]  MODE_RW_MASK   = 8'hFC;
    localparam logic [3:0]  TC_ALL         = 4'hF;
    // Reset values
    localparam logic [15:0] ADDR_RST       = 16'h0000;
    localparam logic [7:0]  PAGE_RST       = 8'h00;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [7:0]  CMD_RST        = 8'h00;
    localparam logic [7:0]  MODE_RST       = 8'h00;
    // Steps
    localparam logic [15:0] STEP_8         = 16'h0001;
    localparam logic [15:0] STEP_16        = 16'h0002;
endpackage : ddmar_pkg

// ---- dv/ddmar_chk_assertions.sv ----
// Port checker for the distributed DMA register bank.
// Assumes it is bound by name onto every ddmar_regs instance.
`timescale 1ns/1ps
module ddmar_chk (
    // Clock, reset and inputs
    input wire logic        clk, reset, io_wr, io_rd, width16,
    input wire logic        xfer_done, chan_reset,
    input wire logic [15:0] io_base, io_addr,
    // Observed outputs
    input wire logic [7:0]  io_rdata,
    input wire logic        io_hit, ctrl_enabled, terminal_count,
    input wire logic [23:0] pci_addr
);
    // Window decode and status read, as the host sees them
    wire hit = io_addr[15:4] == io_base[15:4];
    wire st  = io_rd && hit && io_addr[3:0] == 4'h8;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_read_hit: assert property (io_rd && hit |=> io_hit)
        else $error("window read unanswered");
    a_read_miss: assert property (io_rd && !hit
        |=> !io_hit && io_rdata == 8'h00) else $error("miss answered");
    a_status_top: assert property (st |=> io_rdata[7:4] == 4'h0)
        else $error("status top nonzero");
    a_unused_bits_zero: assert property (io_rd && hit &&
        io_addr[3:0] == 4'h3 |=> io_rdata == 8'h00)
        else $error("reserved byte nonzero");
    a_status_clears: assert property (st && !xfer_done
        |=> !terminal_count) else $error("flags not cleared");
    a_flags_hold: assert property (terminal_count && !chan_reset &&
        !st |=> terminal_count) else $error("flags dropped");
    a_wide_ad0: assert property (width16 && $past(width16)
        |-> !pci_addr[0]) else $error("wide image bit 0 set");
    a_enable_reset: assert property ($fell(reset) && !io_wr
        |=> ctrl_enabled) else $error("not enabled after reset");
endmodule : ddmar_chk

bind ddmar_regs ddmar_chk chk (.*);

// ---- dv/ddmar_seq.sv ----
// Transfer sequencer model: pulses the completion strobe.
// Assumes run() is called from a falling clock edge.
`timescale 1ns/1ps
module ddmar_seq (
    // Clock and completion strobe
    input wire logic clk,
    output logic     xfer_done
);
    initial xfer_done = 1'b0;
    // One-cycle pulses with a gap, like a slow card
    task automatic run(input int n);
        repeat (n) begin
            @(negedge clk);
            xfer_done = 1'b1;
            @(negedge clk);
            xfer_done = 1'b0;
        end
    endtask : run
endmodule : ddmar_seq

// ---- dv/ddmar_regs_tb.sv ----
// Bench: host byte accesses, sequencer steps, queued read checks.
// Assumes ddmar_seq drives the completion strobe.
`timescale 1ns/1ps
module distributed_dma_slave_regs_tb_top;
    localparam logic [15:0] B = 16'h0340;
    logic        clk, reset, io_wr, io_rd, width16, chan_reset, io_hit;
    logic        xfer_done, ctrl_enabled, terminal_count;
    logic [15:0] io_addr, a, io_base, nb;
    logic [7:0]  io_wdata, io_rdata, p, exp_q[$];
    logic [23:0] pci_addr;
    int          mismatches, n_tests;
    ddmar_regs dut (.clk, .reset, .io_base, .io_addr, .io_wr, .io_rd,
        .io_wdata, .io_rdata, .io_hit, .width16, .xfer_done, .chan_reset,
        .pci_addr, .ctrl_enabled, .terminal_count);
    ddmar_seq seq (.clk, .xfer_done);
    task automatic check(input logic [23:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %0t: saw %h want %h", $time, s, e);
        end
    endtask : check
    // Host byte access a window read queues its expected byte
    task automatic io(input logic w, input logic [15:0] ad, d);
        @(negedge clk);
        io_addr = ad;
        io_wdata = d[7:0];
        io_wr = w;
        io_rd = !w;
        if (!w && ad[15:4] == io_base[15:4]) exp_q.push_back(d[7:0]);
        @(negedge clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask : io
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // Clock, and a watchdog against hangs
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    // Oldest queued byte against each answer
    always @(negedge clk) begin
        if (io_hit === 1'b1) begin
            if (exp_q.size() == 0) check(24'h1, 24'h0);
            else check(io_rdata, exp_q.pop_front());
        end
    end
    initial begin
        {io_wr, io_rd, width16, chan_reset, io_addr, io_wdata} = '0;
        io_base = B;
        reset = 1'b1;
        void'($urandom(32'h548F));
        a = 16'($urandom);
        p = 8'($urandom);
        repeat (16) @(negedge clk);
        reset = 1'b0;
        for (int o = 0; o < 16; o++) io(1'b0, B + 16'(o), 16'h0);
        io(1'b0, B ^ 16'h0100, 16'h0);
        nb = (B ^ (16'($urandom) | 16'h0010)) & 16'hFFF0;
        @(negedge clk);
        io_base = nb;
        io(1'b0, nb + 16'h2, 16'h0);
        io(1'b0, B + 16'h2, 16'h0);
        @(negedge clk);
        io_base = B;
        $display("test reset done");
        io(1'b1, B, a[7:0]);
        io(1'b1, B + 16'h1, a[15:8]);
        io(1'b1, B + 16'h2, p);
        io(1'b1, B + 16'h4, 16'h5);
        io(1'b1, B + 16'h3, 16'hFF);
        io(1'b0, B + 16'h1, a[15:8]);
        io(1'b0, B + 16'h2, p);
        io(1'b0, B + 16'h3, 16'h0);
        check(pci_addr, {p, a});
        seq.run(1);
        io(1'b0, B, 8'(a[7:0] + 8'h01));
        io(1'b1, B + 16'hB, 16'h20);
        seq.run(1);
        io(1'b0, B, a[7:0]);
        io(1'b0, B + 16'h4, 16'h3);
        io(1'b1, B + 16'h8, 16'hFF);
        check(ctrl_enabled, 1'b0);
        seq.run(1);
        io(1'b0, B + 16'h4, 16'h3);
        io(1'b0, B + 16'h8, 16'h0);
        io(1'b1, B + 16'h8, 16'h0);
        check(ctrl_enabled, 1'b1);
        $display("test narrow done");
        width16 = 1'b1;
        io(1'b1, B + 16'hB, 16'h0);
        check(pci_addr, {p[7:1], a, 1'b0});
        seq.run(1);
        io(1'b0, B + 16'h4, 16'h1);
        seq.run(1);
        check(terminal_count, 1'b1);
        io(1'b0, B + 16'h8, 16'hF);
        check(terminal_count, 1'b0);
        io(1'b1, B + 16'h4, 16'h2);
        io(1'b1, B + 16'h5, 16'h0);
        seq.run(1);
        @(negedge clk);
        chan_reset = 1'b1;
        @(negedge clk);
        chan_reset = 1'b0;
        check(terminal_count, 1'b0);
        $display("test wide done");
        repeat (4) @(negedge clk);
        check(24'(exp_q.size()), 24'h0);
        close_out();
    end
endmodule : distributed_dma_slave_regs_tb_top
